// ==== core/poe_seq_pkg.sv ====
// constants, tables and types shared by the port sequencing logic
package poe_seq_pkg;
	// ==========================================================
	// clock and time base
	localparam int CLK_PERIOD_NS  = 10;
	localparam int TICK_PERIOD_MS = 1;
	localparam int TICK_CYCLES    = TICK_PERIOD_MS * 1000000 / CLK_PERIOD_NS;
	localparam int SLOW_DIV       = 16;
	localparam int SLOW_W         = 4;
	localparam int TICK_W         = 20;
	localparam int TIME_W         = 10;
	// ==========================================================
	// register offsets and reset values
	localparam logic [7:0] ADDR_POWER_STATUS = 8'h10;
	localparam logic [7:0] ADDR_DISC_EN      = 8'h13;
	localparam logic [7:0] ADDR_DC_EN        = 8'h14;
	localparam logic [7:0] ADDR_PRIORITY     = 8'h15;
	localparam logic [7:0] ADDR_TIMING       = 8'h16;
	localparam logic [7:0] DISC_EN_RESET     = 8'h00;
	localparam logic [7:0] PRIORITY_RESET    = 8'h00;
	localparam logic [7:0] TIMING_RESET      = 8'h00;
	localparam logic [3:0] DC_BITS_RESET     = 4'h0;
	// ==========================================================
	// timing field positions in the shared configuration byte, and the fast-off select field in the priority byte
	localparam int LIM_POS   = 6;
	localparam int START_POS = 4;
	localparam int OVL_POS   = 2;
	localparam int DIS_POS   = 0;
	localparam int FSO_POS   = 4;
	// ==========================================================
	// durations in milliseconds, indexed by the field code
	localparam logic [TIME_W-1:0] LIM_DEFAULT_MS = 10'h03C;
	localparam logic [TIME_W-1:0] LIM_MS [4] =
		'{10'h03C, 10'h01E, 10'h00F, 10'h00A};
	// code 11 is reserved; it behaves like code 00
	localparam logic [TIME_W-1:0] START_MS [4] =
		'{10'h03C, 10'h01E, 10'h078, 10'h03C};
	localparam logic [TIME_W-1:0] OVL_MS [4] =
		'{10'h03C, 10'h01E, 10'h078, 10'h0F0};
	localparam logic [TIME_W-1:0] DIS_MS [4] =
		'{10'h168, 10'h05A, 10'h0B4, 10'h2D0};
	// 13 percent of each interval, rounded up to whole ms
	localparam logic [TIME_W-1:0] DIS_HOLD_MS [4] =
		'{10'h02F, 10'h00C, 10'h018, 10'h05E};
	localparam logic [TIME_W-1:0] COOLDOWN_MS = 10'h3E8;
	// ==========================================================
	// codes
	localparam logic [1:0] MODE_OFF    = 2'h0;
	localparam logic [1:0] MODE_MANUAL = 2'h1;
	localparam logic [1:0] MODE_SEMI   = 2'h2;
	localparam logic [1:0] MODE_AUTO   = 2'h3;
	localparam logic [3:0] DET_VALID     = 4'h4;
	localparam logic [3:0] CLS_UNKNOWN   = 4'h0;
	localparam logic [3:0] CLS_OVERCUR   = 4'h7;
	localparam logic [3:0] CLS_MISMATCH  = 4'h8;
	typedef enum logic [4:0] {
		ST_IDLE   = 5'h01,
		ST_DETECT = 5'h02,
		ST_CLASS  = 5'h04,
		ST_ON     = 5'h08,
		ST_COOL   = 5'h10
	} port_state_t;
endpackage

// ==== core/port_timer_if.sv ====
// signals between a port sequencer and its fault timers
`timescale 1ns/1ps
`default_nettype none
interface port_timer_if;
	logic       tick;
	logic       slow_tick;
	logic       powered;
	logic       start;
	logic       foldback;
	logic       overload;
	logic       clamped;
	logic       below_disc;
	logic       disc_en;
	logic       high_power;
	logic [7:0] cfg;
	logic       fault;
	logic       disc_timeout;
	modport seq (output tick, slow_tick, powered, start, foldback, overload,
		clamped, below_disc, disc_en, high_power, cfg,
		input fault, disc_timeout);
	modport timer (input tick, slow_tick, powered, start, foldback,
		overload, clamped, below_disc, disc_en, high_power, cfg,
		output fault, disc_timeout);
endinterface
`default_nettype wire

// ==== core/port_fault_timers.sv ====
// inrush, current-limit, overload and disconnect timers of one port
`timescale 1ns/1ps
`default_nettype none
module port_fault_timers (
	input  wire logic   clk,
	input  wire logic   reset_n,
	port_timer_if.timer t
);
	import poe_seq_pkg::*;
	// ==========================================================
	// full counts from the shared configuration byte; the limit count comes from it only with high_power, else LIM_DEFAULT_MS
	wire [1:0] lim_sel = t.cfg[LIM_POS +: 2];
	wire [1:0] str_sel = t.cfg[START_POS +: 2];
	wire [1:0] ovl_sel = t.cfg[OVL_POS +: 2];
	wire [1:0] dis_sel = t.cfg[DIS_POS +: 2];
	wire [TIME_W-1:0] lim_full = t.high_power ? LIM_MS[lim_sel]
		: LIM_DEFAULT_MS;
	wire [TIME_W-1:0] str_full = START_MS[str_sel];
	wire [TIME_W-1:0] ovl_full = OVL_MS[ovl_sel];
	wire [TIME_W-1:0] dis_full = DIS_MS[dis_sel];
	wire [TIME_W-1:0] hold_full = DIS_HOLD_MS[dis_sel];
	logic              in_inrush;
	logic              running;
	logic [TIME_W-1:0] ir_cnt;
	logic [TIME_W-1:0] lim_cnt;
	logic [TIME_W-1:0] ovl_cnt;
	logic [TIME_W-1:0] dis_cnt;
	logic [TIME_W-1:0] hold_cnt;
	// ==========================================================
	// decisions
	wire inrush_end = in_inrush & t.tick & (ir_cnt <= 10'h001);
	wire start_fault = inrush_end & t.clamped;
	wire lim_fault = running & t.tick & t.foldback
		& (lim_cnt <= 10'h001);
	wire ovl_fault = running & t.tick & t.overload
		& (ovl_cnt <= 10'h001);
	wire dis_armed = running & t.disc_en;
	wire dis_end = dis_armed & t.below_disc & t.tick
		& (dis_cnt + 10'h001 >= dis_full);
	wire hold_hit = t.tick & (hold_cnt + 10'h001 >= hold_full);
	// the limit and overload counters creep back up at 1/16 speed
	wire [TIME_W-1:0] next_lim = (lim_cnt > lim_full) ? lim_full
		: t.foldback ? (t.tick ? lim_cnt - 10'h001 : lim_cnt)
		: (t.slow_tick && lim_cnt < lim_full) ? lim_cnt + 10'h001
		: lim_cnt;
	wire [TIME_W-1:0] next_ovl = (ovl_cnt > ovl_full) ? ovl_full
		: t.overload ? (t.tick ? ovl_cnt - 10'h001 : ovl_cnt)
		: (t.slow_tick && ovl_cnt < ovl_full) ? ovl_cnt + 10'h001
		: ovl_cnt;
	// ==========================================================
	// inrush window and fault timers
	always_ff @(posedge clk or negedge reset_n) begin
		if (!reset_n) begin
			in_inrush <= 1'b0;
			running   <= 1'b0;
			ir_cnt    <= '0;
			lim_cnt   <= '0;
			ovl_cnt   <= '0;
		end else if (!t.powered) begin
			in_inrush <= 1'b0;
			running   <= 1'b0;
		end else if (t.start) begin
			in_inrush <= 1'b1;
			ir_cnt    <= str_full;
		end else if (inrush_end) begin
			in_inrush <= 1'b0;
			running   <= !t.clamped;
			lim_cnt   <= lim_full;
			ovl_cnt   <= ovl_full;
		end else if (in_inrush) begin
			ir_cnt <= t.tick ? ir_cnt - 10'h001 : ir_cnt;
		end else if (running) begin
			lim_cnt <= next_lim;
			ovl_cnt <= next_ovl;
		end
	end
	// ==========================================================
	// disconnect: elapsed time below threshold, never under zero
	always_ff @(posedge clk or negedge reset_n) begin
		if (!reset_n) begin
			dis_cnt  <= '0;
			hold_cnt <= '0;
		end else if (!dis_armed) begin
			dis_cnt  <= '0;
			hold_cnt <= '0;
		end else if (t.below_disc) begin
			hold_cnt <= '0;
			dis_cnt  <= t.tick ? dis_cnt + 10'h001 : dis_cnt;
		end else if (hold_hit) begin
			hold_cnt <= '0;
			dis_cnt  <= '0;
		end else begin
			hold_cnt <= t.tick ? hold_cnt + 10'h001 : hold_cnt;
		end
	end
	always_ff @(posedge clk or negedge reset_n) begin
		if (!reset_n) begin
			t.fault        <= 1'b0;
			t.disc_timeout <= 1'b0;
		end else begin
			t.fault        <= start_fault | lim_fault | ovl_fault;
			t.disc_timeout <= dis_end;
		end
	end
endmodule
`default_nettype wire

// ==== core/poe_port_sequencing_timers.sv ====
// four-port power sequencing, fault timers and their configuration
`timescale 1ns/1ps
`default_nettype none
module poe_port_sequencing_timers #(
	parameter int PORTS       = 4,
	parameter int TICK_CYCLES = poe_seq_pkg::TICK_CYCLES
) (
	input  wire logic         clk,
	input  wire logic         reset_n,
	input  wire logic         reg_write,
	input  wire logic [7:0]   reg_addr,
	input  wire logic [7:0]   reg_wdata,
	input  wire logic [7:0]   port_mode,
	input  wire logic [3:0]   power_on_cmd,
	input  wire logic [3:0]   power_off_cmd,
	input  wire logic [3:0]   high_power_en,
	input  wire logic         fast_shutdown_n,
	input  wire logic [3:0]   foldback_limit,
	input  wire logic [3:0]   overload_threshold,
	input  wire logic [3:0]   inrush_clamped,
	input  wire logic [3:0]   below_disconnect,
	input  wire logic [3:0]   drain_good,
	input  wire logic [3:0]   detect_done,
	input  wire logic [15:0]  detect_result,
	input  wire logic [3:0]   class_done,
	input  wire logic [15:0]  class_result,
	output logic [3:0]        detect_start,
	output logic [3:0]        class_start,
	output logic [3:0]        power_on_state,
	output logic [3:0]        power_good,
	output logic [3:0]        disconnect_fault_flag,
	output logic [3:0]        cooldown_active,
	output logic [7:0]        reg_rdata
);
	import poe_seq_pkg::*;
	// ==========================================================
	// configuration registers
	logic [7:0] disconnect_enable;
	logic [7:0] port_shutdown_priority;
	logic [7:0] fault_timing_config;
	logic [3:0] detect_en;
	logic [3:0] classify_en;
	wire wr_disc = reg_write & (reg_addr == ADDR_DISC_EN);
	wire wr_dc   = reg_write & (reg_addr == ADDR_DC_EN);
	wire wr_prio = reg_write & (reg_addr == ADDR_PRIORITY);
	wire wr_time = reg_write & (reg_addr == ADDR_TIMING);
	wire [3:0] disconnect_detect_en = disconnect_enable[3:0];
	wire [3:0] fast_off_select = port_shutdown_priority[FSO_POS +: 4];
	// writes to other commands, status included, are dropped
	// upper nibble of the disconnect register is stored but reads back as zero
	wire [7:0] read_mux =
		(reg_addr == ADDR_POWER_STATUS) ? {power_good, power_on_state}
		: (reg_addr == ADDR_DISC_EN) ? {4'h0, disconnect_detect_en}
		: (reg_addr == ADDR_DC_EN) ? {classify_en, detect_en}
		: (reg_addr == ADDR_PRIORITY) ? port_shutdown_priority
		: (reg_addr == ADDR_TIMING) ? fault_timing_config
		: 8'h00;
	always_ff @(posedge clk or negedge reset_n) begin
		if (!reset_n) begin
			disconnect_enable      <= DISC_EN_RESET;
			port_shutdown_priority <= PRIORITY_RESET;
			fault_timing_config    <= TIMING_RESET;
			reg_rdata              <= 8'h00;
		end else begin
			if (wr_disc)
				disconnect_enable <= reg_wdata;
			if (wr_prio)
				port_shutdown_priority <= reg_wdata;
			if (wr_time)
				fault_timing_config <= reg_wdata;
			reg_rdata <= read_mux;
		end
	end
	// ==========================================================
	// shared time base: 1 ms tick and a 1/16 recovery tick
	logic [TICK_W-1:0] tick_cnt;
	logic [SLOW_W-1:0] slow_cnt;
	logic              tick;
	logic              slow_tick;
	// the 1/16 tick always lands on a 1 ms tick
	wire tick_wrap = (tick_cnt == TICK_W'(TICK_CYCLES - 1));
	always_ff @(posedge clk or negedge reset_n) begin
		if (!reset_n) begin
			tick_cnt  <= '0;
			slow_cnt  <= '0;
			tick      <= 1'b0;
			slow_tick <= 1'b0;
		end else begin
			tick_cnt  <= tick_wrap ? '0 : tick_cnt + 1'b1;
			tick      <= tick_wrap;
			slow_tick <= tick_wrap & (slow_cnt == SLOW_W'(SLOW_DIV - 1));
			if (tick_wrap)
				slow_cnt <= slow_cnt + 1'b1;
		end
	end
	// ==========================================================
	// per-port sequencer
	genvar i;
	generate
		for (i = 0; i < PORTS; i++) begin : g_port
			port_timer_if tif();
			port_state_t       state;
			port_state_t       next_state;
			logic [TIME_W-1:0] cool_cnt;
			logic              pend_valid;
			logic              pend_det;
			logic              pend_cls;
			logic              on_d;
			wire [1:0] mode = port_mode[2*i +: 2];
			wire manual = (mode == MODE_MANUAL);
			wire mode_off = (mode == MODE_OFF);
			wire in_cool = (state == ST_COOL);
			// select bits are read live: a port picked while the pin
			// is already low goes off as well
			wire shut = ~fast_shutdown_n & fast_off_select[i];
			wire off_cmd = power_off_cmd[i] | shut;
			wire on_cmd = power_on_cmd[i] & ~off_cmd & ~mode_off;
			wire [3:0] det_res = detect_result[4*i +: 4];
			wire [3:0] cls_res = class_result[4*i +: 4];
			wire det_ok = (det_res == DET_VALID);
			wire cls_bad = (cls_res == CLS_UNKNOWN)
				| (cls_res == CLS_OVERCUR) | (cls_res == CLS_MISMATCH);
			wire cool_end = in_cool & tick & (cool_cnt <= 10'h001);
			wire det_fin = (state == ST_DETECT) & detect_done[i];
			wire cls_fin = (state == ST_CLASS) & class_done[i];
			// the status flop rises with the state, so the timers take
			// their power-up pulse from a delayed copy
			wire powered_now = (state == ST_ON);
			wire power_up = powered_now & ~on_d;
			wire disc_trip = tif.disc_timeout & powered_now;
			assign tif.tick       = tick;
			assign tif.slow_tick  = slow_tick;
			assign tif.powered    = powered_now;
			assign tif.start      = power_up;
			assign tif.foldback   = foldback_limit[i];
			assign tif.overload   = overload_threshold[i];
			assign tif.clamped    = inrush_clamped[i];
			assign tif.below_disc = below_disconnect[i];
			assign tif.disc_en    = disconnect_detect_en[i];
			assign tif.high_power = high_power_en[i];
			assign tif.cfg        = fault_timing_config;
			// all ports share one tick, so their timers keep pace
			port_fault_timers u_timers (
				.clk     (clk),
				.reset_n (reset_n),
				.t       (tif)
			);
			// off mode wins over every other request; power-off does too, except over a detect or class start from idle
			always_comb begin
				next_state = state;
				case (state)
				ST_IDLE: begin
					if (mode_off || shut)
						next_state = ST_IDLE;
					else if (on_cmd)
						next_state = ST_ON;
					else if (detect_en[i])
						next_state = ST_DETECT;
					else if (manual && classify_en[i])
						next_state = ST_CLASS;
				end
				ST_DETECT: begin
					if (mode_off || off_cmd)
						next_state = ST_IDLE;
					else if (det_fin)
						next_state = (!manual && det_ok && classify_en[i])
							? ST_CLASS : ST_IDLE;
				end
				ST_CLASS: begin
					if (mode_off || off_cmd)
						next_state = ST_IDLE;
					else if (cls_fin)
						next_state = (mode == MODE_AUTO && !cls_bad)
							? ST_ON : ST_IDLE;
				end
				ST_ON: begin
					// a fault outranks a disconnect timeout
					if (mode_off || off_cmd)
						next_state = ST_IDLE;
					else if (tif.fault)
						next_state = ST_COOL;
					else if (tif.disc_timeout)
						next_state = ST_IDLE;
				end
				ST_COOL: begin
					// only manual mode may power up during cool-down
					if (mode_off)
						next_state = ST_IDLE;
					else if (manual && on_cmd)
						next_state = ST_ON;
					else if (cool_end)
						next_state = ST_IDLE;
				end
				default: next_state = ST_IDLE;
				endcase
			end
			always_ff @(posedge clk or negedge reset_n) begin
				if (!reset_n) begin
					state    <= ST_IDLE;
					cool_cnt <= '0;
					on_d     <= 1'b0;
				end else begin
					state <= next_state;
					on_d  <= powered_now;
					// reloaded outside cool-down so each one runs in full
					if (state != ST_COOL)
						cool_cnt <= COOLDOWN_MS;
					else if (tick)
						cool_cnt <= cool_cnt - 10'h001;
				end
			end
			// enable writes during cool-down wait in a pending slot
			// a later write in the same cool-down replaces the earlier
			always_ff @(posedge clk or negedge reset_n) begin
				if (!reset_n) begin
					pend_valid <= 1'b0;
					pend_det   <= 1'b0;
					pend_cls   <= 1'b0;
				end else if (wr_dc && in_cool) begin
					pend_valid <= 1'b1;
					pend_det   <= reg_wdata[i];
					pend_cls   <= reg_wdata[4+i];
				end else if (!in_cool) begin
					pend_valid <= 1'b0;
				end
			end
			// a register write wins over a hardware clear
			always_ff @(posedge clk or negedge reset_n) begin
				if (!reset_n) begin
					detect_en[i]   <= DC_BITS_RESET[i];
					classify_en[i] <= DC_BITS_RESET[i];
				end else if (wr_dc && !in_cool) begin
					detect_en[i]   <= reg_wdata[i];
					classify_en[i] <= reg_wdata[4+i];
				end else if (cool_end && pend_valid) begin
					detect_en[i]   <= pend_det;
					classify_en[i] <= pend_cls;
				end else if (off_cmd) begin
					detect_en[i]   <= 1'b0;
					classify_en[i] <= 1'b0;
				end else if (manual) begin
					if (det_fin)
						detect_en[i] <= 1'b0;
					if (cls_fin)
						classify_en[i] <= 1'b0;
				end
			end
			always_ff @(posedge clk or negedge reset_n) begin
				if (!reset_n) begin
					detect_start[i]          <= 1'b0;
					class_start[i]           <= 1'b0;
					power_on_state[i]        <= 1'b0;
					power_good[i]            <= 1'b0;
					cooldown_active[i]       <= 1'b0;
					disconnect_fault_flag[i] <= 1'b0;
				end else begin
					detect_start[i] <= (next_state == ST_DETECT)
						& (state != ST_DETECT);
					class_start[i] <= (next_state == ST_CLASS)
						& (state != ST_CLASS);
					power_on_state[i] <= (next_state == ST_ON);
					power_good[i] <= (next_state == ST_ON)
						& (power_good[i] | drain_good[i]);
					cooldown_active[i] <= (next_state == ST_COOL);
					// a timeout outranks the off push that clears the flag
					if (disc_trip)
						disconnect_fault_flag[i] <= 1'b1;
					else if (power_off_cmd[i])
						disconnect_fault_flag[i] <= 1'b0;
				end
			end
		end
	endgenerate
endmodule
`default_nettype wire

// ==== test/poe_seq_properties.sv ====
// assertion checker for the four-port sequencing block
`timescale 1ns/1ps
`default_nettype none
module poe_seq_checker
	import poe_seq_pkg::*;
#(
	parameter int TICK_CYCLES = 10
) (
	input wire logic        clk,
	input wire logic        reset_n,
	input wire logic [7:0]  port_mode,
	input wire logic [3:0]  power_on_cmd,
	input wire logic [3:0]  power_off_cmd,
	input wire logic [3:0]  detect_done,
	input wire logic [15:0] detect_result,
	input wire logic [3:0]  class_done,
	input wire logic [15:0] class_result,
	input wire logic [3:0]  detect_start,
	input wire logic [3:0]  class_start,
	input wire logic [3:0]  power_on_state,
	input wire logic [3:0]  power_good,
	input wire logic [3:0]  disconnect_fault_flag,
	input wire logic [3:0]  cooldown_active
);
	wire cls_ok = !(class_result[3:0] inside
		{CLS_UNKNOWN, CLS_OVERCUR, CLS_MISMATCH});
	default clocking @(posedge clk); endclocking
	default disable iff (!reset_n);
	// ==========================================================
	// the first two checks cover all four ports, the rest watch port 0 alone; the logic is replicated per port
	AST_COOL_IDLE: assert property (
		(cooldown_active & (power_on_state | detect_start | class_start)) == 0)
		else $error("port active during cool-down");
	AST_PG_ON: assert property ((power_good & ~power_on_state) == 0)
		else $error("power good without power");
	AST_OFF_CMD: assert property (
		power_off_cmd[0] |=> !power_on_state[0])
		else $error("port stayed on after off command");
	AST_CLASS_VALID: assert property (
		class_start[0] && port_mode[1:0] == MODE_SEMI |->
		$past(detect_done[0]) && $past(detect_result[3:0]) == DET_VALID)
		else $error("classification without valid detection");
	AST_AUTO_ON: assert property (
		$rose(power_on_state[0]) && !$past(power_on_cmd[0]) |->
		$past(class_done[0]) && $past(cls_ok))
		else $error("automatic power-on without good class");
	AST_MODE_OFF: assert property (
		$past(port_mode[1:0]) == MODE_OFF && port_mode[1:0] == MODE_OFF |->
		!detect_start[0] && !class_start[0])
		else $error("cycle started in off mode");
	AST_DISC_OFF: assert property (
		$rose(disconnect_fault_flag[0]) |-> $fell(power_on_state[0]))
		else $error("disconnect flag without power-off");
	AST_COOL_FROM_ON: assert property (
		$rose(cooldown_active[0]) |-> $past(power_on_state[0]))
		else $error("cool-down entered from unpowered port");
	AST_COOL_HOLD: assert property (
		$rose(cooldown_active[0]) |=> cooldown_active[0] [*8])
		else $error("cool-down ended early");
	cover property ($rose(power_on_state[0]));
	cover property ($rose(cooldown_active[0]));
	cover property ($rose(disconnect_fault_flag[0]));
endmodule
bind poe_port_sequencing_timers poe_seq_checker #(
	.TICK_CYCLES(TICK_CYCLES)
) props (
	.clk, .reset_n, .port_mode, .power_on_cmd, .power_off_cmd,
	.detect_done, .detect_result, .class_done, .class_result,
	.detect_start, .class_start, .power_on_state, .power_good,
	.disconnect_fault_flag, .cooldown_active
);
`default_nettype wire

// ==== test/port_front_end.sv ====
// behavioural port front end answering detection and classification
`timescale 1ns/1ps
`default_nettype none
module port_front_end (
	input  wire logic        clk,
	input  wire logic        reset_n,
	input  wire logic        slow,
	input  wire logic [3:0]  det_code,
	input  wire logic [3:0]  cls_code,
	input  wire logic [3:0]  detect_start,
	input  wire logic [3:0]  class_start,
	output logic [3:0]       detect_done,
	output logic [15:0]      detect_result,
	output logic [3:0]       class_done,
	output logic [15:0]      class_result
);
	logic [3:0] dcnt [4];
	logic [3:0] ccnt [4];
	// results are inverted outside the done cycle so stale reads show up
	always @(posedge clk or negedge reset_n) begin
		for (int i = 0; i < 4; i++) begin
			if (!reset_n) begin
				dcnt[i] <= 4'h0;
				ccnt[i] <= 4'h0;
				detect_done[i] <= 1'b0;
				class_done[i] <= 1'b0;
			end else begin
				dcnt[i] <= detect_start[i] ? (slow ? 4'h9 : 4'h2) :
					dcnt[i] - (dcnt[i] != 0);
				ccnt[i] <= class_start[i] ? (slow ? 4'h9 : 4'h2) :
					ccnt[i] - (ccnt[i] != 0);
				detect_done[i] <= dcnt[i] == 4'h1;
				class_done[i] <= ccnt[i] == 4'h1;
			end
			detect_result[i*4 +: 4] <= (dcnt[i] == 4'h1) ? det_code : ~det_code;
			class_result[i*4 +: 4] <= (ccnt[i] == 4'h1) ? cls_code : ~cls_code;
		end
	end
endmodule
`default_nettype wire

// ==== test/testbench.sv ====
// self-checking bench for the four-port sequencing block
`timescale 1ns/1ps
`default_nettype none
module testbench;
	import poe_seq_pkg::*;
	localparam int TK = 10;
	localparam logic [3:0] CODES [4] =
		'{CLS_UNKNOWN, CLS_OVERCUR, CLS_MISMATCH, 4'h3};
	logic        clk, reset_n, reg_write, fast_shutdown_n, slow;
	logic [7:0]  reg_addr, reg_wdata, port_mode, reg_rdata, rd, v;
	logic [3:0]  power_on_cmd, power_off_cmd, high_power_en, foldback_limit;
	logic [3:0]  overload_threshold, inrush_clamped, below_disconnect;
	logic [3:0]  drain_good, det_code, cls_code, detect_done, class_done;
	logic [3:0]  detect_start, class_start, power_on_state, power_good;
	logic [3:0]  disconnect_fault_flag, cooldown_active;
	logic [15:0] detect_result, class_result;
	logic [31:0] seed;
	int          miscompares, samples_checked, cycles, n, k, m, i;
	poe_port_sequencing_timers #(.TICK_CYCLES(TK)) dut (
		.clk, .reset_n, .reg_write, .reg_addr, .reg_wdata, .port_mode,
		.power_on_cmd, .power_off_cmd, .high_power_en, .fast_shutdown_n,
		.foldback_limit, .overload_threshold, .inrush_clamped,
		.below_disconnect, .drain_good, .detect_done, .detect_result,
		.class_done, .class_result, .detect_start, .class_start,
		.power_on_state, .power_good, .disconnect_fault_flag,
		.cooldown_active, .reg_rdata
	);
	port_front_end far_end (
		.clk, .reset_n, .slow, .det_code, .cls_code, .detect_start,
		.class_start, .detect_done, .detect_result, .class_done, .class_result
	);
	initial begin
		clk = 1'b0;
		forever #5 clk = ~clk;
	end
	// ==========================================================
	// helpers
	function automatic logic [31:0] xs(input logic [31:0] s);
		logic [31:0] x;
		x = s ^ (s << 13);
		x = x ^ (x >> 17);
		return x ^ (x << 5);
	endfunction
	function automatic logic sig(input int s);
		case (s)
			0: return class_start[0];
			1: return detect_start[0];
			4: return !power_on_state[0];
			default: return !cooldown_active[0];
		endcase
	endfunction
	task automatic chk(input string what, input logic [7:0] e, input logic [7:0] g);
		samples_checked++;
		if (g !== e) begin
			miscompares++;
			$display("BAD %s expected %h seen %h", what, e, g);
		end
	endtask
	task automatic wr(input logic [7:0] a, input logic [7:0] d);
		@(posedge clk);
		reg_write <= 1'b1;
		reg_addr <= a;
		reg_wdata <= d;
		@(posedge clk);
		reg_write <= 1'b0;
		#1;
	endtask
	task automatic rdreg(input logic [7:0] a);
		@(posedge clk);
		reg_addr <= a;
		repeat (2) @(posedge clk);
		#1 rd = reg_rdata;
	endtask
	task automatic cmd(input logic [3:0] on, input logic [3:0] off);
		@(posedge clk);
		power_on_cmd <= on;
		power_off_cmd <= off;
		@(posedge clk);
		power_on_cmd <= 4'h0;
		power_off_cmd <= 4'h0;
		#1;
	endtask
	task automatic wt(input int s, input int lim);
		for (n = 0; n < lim && sig(s) !== 1'b1; n++) begin
			@(posedge clk);
			#1;
		end
	endtask
	task automatic count(input int c);
		k = 0;
		m = 0;
		repeat (c) begin
			@(posedge clk);
			#1;
			k += detect_start[0];
			m += class_start[0];
		end
	endtask
	task automatic stop_test;
		$display("checked %0d mismatches %0d", samples_checked, miscompares);
		if (miscompares == 0 && samples_checked > 0)
			$display("Regression OK");
		else
			$display("Regression broken");
		$finish;
	endtask
	always @(posedge clk) begin
		cycles <= cycles + 1;
		if (cycles == 30000) begin
			miscompares++;
			$display("BAD run length expected finish seen hang");
			stop_test();
		end
	end
	// ==========================================================
	// main sequence
	initial begin
		{reg_write, reg_addr, reg_wdata, port_mode, power_on_cmd} = '0;
		{power_off_cmd, high_power_en, foldback_limit, slow} = '0;
		{overload_threshold, inrush_clamped, below_disconnect} = '0;
		{drain_good, det_code, cls_code, cycles} = '0;
		{miscompares, samples_checked} = '0;
		fast_shutdown_n = 1'b1;
		seed = 32'h0000_0001;
		reset_n = 1'b0;
		repeat (8) @(posedge clk);
		reset_n <= 1'b1;
		for (i = 0; i < 4; i++) begin
			rdreg(ADDR_DISC_EN + i[7:0]);
			chk("reset value", 8'h00, rd);
		end
		repeat (4) begin
			seed = xs(seed);
			v = seed[7:0];
			high_power_en <= seed[11:8];
			wr(ADDR_DISC_EN, v);
			wr(ADDR_PRIORITY, {v[7:4], 4'h0});
			wr(ADDR_TIMING, v);
			wr(8'h20, v);
			rdreg(ADDR_DISC_EN);
			chk("disconnect enable", {4'h0, v[3:0]}, rd);
			rdreg(ADDR_PRIORITY);
			chk("priority", {v[7:4], 4'h0}, rd);
			rdreg(ADDR_TIMING);
			chk("timing", v, rd);
			rdreg(8'h20);
			chk("unmapped", 8'h00, rd);
		end
		wr(ADDR_DISC_EN, 8'h00);
		wr(ADDR_PRIORITY, 8'h00);
		wr(ADDR_TIMING, 8'h00);
		$display("test registers done");
		slow <= seed[12];
		det_code <= DET_VALID;
		drain_good <= 4'hF;
		port_mode <= {6'h00, MODE_SEMI};
		wr(ADDR_DC_EN, 8'h11);
		wt(0, 100);
		chk("class after valid", 8'h01, {7'h0, class_start[0]});
		det_code <= 4'h3;
		count(30);
		count(80);
		chk("detect repeats", 8'h01, {7'h0, k >= 3});
		chk("class skipped", 8'h00, m[7:0]);
		cmd(4'h0, 4'h1);
		rdreg(ADDR_DC_EN);
		chk("off clears enables", 8'h00, rd);
		$display("test semi-auto done");
		det_code <= DET_VALID;
		port_mode <= {6'h00, MODE_MANUAL};
		repeat (20) @(posedge clk);
		wr(ADDR_DC_EN, 8'h01);
		wt(1, 50);
		count(20);
		rdreg(ADDR_DC_EN);
		chk("manual self-clear", 8'h00, rd);
		chk("manual one cycle", 8'h00, k[7:0]);
		$display("test manual done");
		port_mode <= {6'h00, MODE_AUTO};
		for (i = 0; i < 4; i++) begin
			cls_code <= CODES[i];
			repeat (20) @(posedge clk);
			wr(ADDR_DC_EN, 8'h11);
			wt(0, 100);
			count(30);
			chk("auto power", {7'h0, i == 3}, {7'h0, power_on_state[0]});
			chk("power good", {7'h0, i == 3}, {7'h0, power_good[0]});
			if (i < 3)
				cmd(4'h0, 4'h1);
		end
		port_mode <= {4'h0, MODE_MANUAL, MODE_AUTO};
		cmd(4'h2, 4'h0);
		wr(ADDR_PRIORITY, 8'h10);
		fast_shutdown_n <= 1'b0;
		count(3);
		chk("fast off selected", 8'h02, {4'h0, power_on_state});
		wr(ADDR_PRIORITY, 8'h30);
		count(3);
		chk("fast off while low", 8'h00, {4'h0, power_on_state});
		fast_shutdown_n <= 1'b1;
		wr(ADDR_PRIORITY, 8'h00);
		$display("test auto and shutdown done");
		port_mode <= {6'h00, MODE_MANUAL};
		wr(ADDR_TIMING, 8'h01);
		wr(ADDR_DISC_EN, 8'h01);
		below_disconnect <= 4'h1;
		cmd(4'h1, 4'h0);
		wt(4, 2000);
		chk("disconnect delay", 8'h01, {7'h0, n >= 89*TK && n <= 152*TK});
		chk("disconnect flag", 8'h01, {7'h0, disconnect_fault_flag[0]});
		cmd(4'h0, 4'h1);
		below_disconnect <= 4'h0;
		wr(ADDR_DISC_EN, 8'h00);
		$display("test disconnect done");
		wr(ADDR_TIMING, 8'h10);
		inrush_clamped <= 4'h1;
		cmd(4'h1, 4'h0);
		wt(4, 400);
		chk("inrush limit", 8'h01, {7'h0, n >= 29*TK && n <= 32*TK});
		count(2);
		chk("cool-down", 8'h01, {7'h0, cooldown_active[0]});
		chk("power good cleared", 8'h00, {4'h0, power_good});
		inrush_clamped <= 4'h0;
		det_code <= 4'h3;
		port_mode <= {6'h00, MODE_SEMI};
		repeat (20) @(posedge clk);
		wr(ADDR_DC_EN, 8'h01);
		rdreg(ADDR_DC_EN);
		chk("enable held", 8'h00, rd);
		wt(5, 10500);
		wt(1, 30);
		chk("restart after cool-down", 8'h01, {7'h0, detect_start[0]});
		rdreg(ADDR_DC_EN);
		chk("held enable applied", 8'h01, rd);
		$display("test start fault done");
		overload_threshold <= 4'h1;
		wr(ADDR_TIMING, 8'h14);
		cmd(4'h0, 4'h1);
		cmd(4'h1, 4'h0);
		wt(4, 800);
		chk("overload time", 8'h01, {7'h0, n >= 59*TK && n <= 62*TK});
		count(2);
		chk("overload cool-down", 8'h01, {7'h0, cooldown_active[0]});
		$display("test overload done");
		stop_test();
	end
endmodule
`default_nettype wire
